//--- verilog/wso_pkg.sv
// Purpose: Constants for the write-once system option register bank.
// Assumes: 8-bit register port, one register per address index.
// Notes: Field placement and reset values are fixed here for the block.
package wso_pkg;
   localparam logic [0:0] ADDR_OPT_A = 1'h0;
   localparam logic [0:0] ADDR_OPT_B = 1'h1;
   // Register A field positions.
   localparam int A_VM_STOP = 0;
   localparam int A_STOP_EN = 1;
   localparam int A_WD_DIS = 2;
   localparam int A_WD_SHORT = 3;
   localparam int A_SHORT_REC = 4;
   localparam int A_VM_PWR = 5;
   localparam int A_VM_RST = 6;
   // Register B field positions.
   localparam int B_EE_CLK = 0;
   localparam int B_VARIANT = 7;
   localparam logic [7:0] RST_OPT_A = 8'h60;
   localparam logic [7:0] RST_OPT_B = 8'h00;
   localparam logic [7:0] MASK_OPT_A = 8'h7f;
   localparam logic [7:0] MASK_OPT_B = 8'h01;
   localparam logic [0:0] VARIANT_VALUE = 1'h1;
   localparam logic [3:0] TRIP_CYCLES = 4'h9;
   localparam logic [12:0] STOP_REC_SHORT = 13'h0020;
   localparam logic [12:0] STOP_REC_LONG = 13'h1000;
   localparam logic [17:0] WD_PERIOD_SHORT = 18'h01ff0;
   localparam logic [17:0] WD_PERIOD_LONG = 18'h3fff0;
endpackage

//--- verilog/wso_trip_filter.sv
// Purpose: Qualifies the voltage monitor trip into a chip reset request.
// Assumes: Trip levels arrive synchronous to clk.
// Notes: Reset request holds until the rising trip level is reached or enable drops.
`timescale 1ns/1ps
`default_nettype none
module wso_trip_filter (
   // Clock and reset.
   input wire logic clk,
   input wire logic reset_n,
   // Monitor controls and levels.
   input wire logic enable,
   input wire logic below_fall,
   input wire logic above_rise,
   // Reset request.
   output logic reset_req
);
   logic [3:0] cnt;
   logic [3:0] next_cnt;
   logic held;
   logic next_held;

   // Count consecutive low cycles; a single good cycle restarts the count.
   always_comb begin
      next_cnt = 4'h0;
      next_held = held;
      if (!enable) begin
         next_held = 1'b0;
      end else if (held) begin
         if (above_rise) begin
            next_held = 1'b0;
         end
      end else if (below_fall) begin
         next_cnt = cnt + 4'h1;
         if (next_cnt == wso_pkg::TRIP_CYCLES) begin
            next_held = 1'b1;
            next_cnt = 4'h0;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt <= 4'h0;
         held <= 1'b0;
      end else begin
         cnt <= next_cnt;
         held <= next_held;
      end
   end

   assign reset_req = held;

   property p_trip_needs_nine;
      @(posedge clk) disable iff (!reset_n)
      $rose(held) |-> $past(below_fall, 1) && $past(below_fall, 9);
   endproperty
   a_trip_needs_nine: assert property (p_trip_needs_nine)
      else $error("Trip reset raised without nine low cycles.");
endmodule
`default_nettype wire

//--- verilog/wso_option_bank.sv
// Purpose: Two write-once option registers driving system option outputs.
// Assumes: Plain register port with read data one cycle after the strobe.
// Notes: Unmapped reads return zero; writes elsewhere are dropped.
`timescale 1ns/1ps
`default_nettype none
module wso_option_bank (
   // Clock and reset.
   input wire logic clk,
   input wire logic reset_n,
   // Register port.
   input wire logic [1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [7:0] rdata,
   // Voltage monitor.
   input wire logic in_stop,
   input wire logic vm_below_fall,
   input wire logic vm_above_rise,
   output logic volt_monitor_power_en,
   output logic volt_monitor_active,
   output logic volt_monitor_reset_en,
   output logic volt_monitor_chip_reset,
   // Stop, watchdog and eeprom options.
   output logic short_stop_recovery,
   output logic [12:0] stop_recovery_cycles,
   output logic stop_instr_enable,
   output logic stop_opcode_illegal,
   output logic watchdog_short_period,
   output logic [17:0] watchdog_period,
   output logic watchdog_disable,
   output logic eeprom_timebase_clk_sel,
   output logic variant_indicator
);
   logic [7:0] opt_a;
   logic [7:0] opt_b;
   logic done_a;
   logic done_b;
   logic [7:0] next_opt_a;
   logic [7:0] next_opt_b;
   logic next_done_a;
   logic next_done_b;
   logic [7:0] next_rdata;
   logic sel_a;
   logic sel_b;
   logic trip_en;

   // Decode one register index; the top address bit must be zero.
   function automatic logic hit(input logic [1:0] a, input logic [0:0] idx);
      hit = (a[1] == 1'b0) && (a[0] == idx);
   endfunction

   assign sel_a = hit(addr, wso_pkg::ADDR_OPT_A);
   assign sel_b = hit(addr, wso_pkg::ADDR_OPT_B);

   // Only the first write after reset lands; the done flag locks it out.
   always_comb begin
      next_opt_a = opt_a;
      next_opt_b = opt_b;
      next_done_a = done_a;
      next_done_b = done_b;
      if (wr_stb && sel_a && !done_a) begin
         next_opt_a = wdata & wso_pkg::MASK_OPT_A;
         next_done_a = 1'b1;
      end
      if (wr_stb && sel_b && !done_b) begin
         next_opt_b = wdata & wso_pkg::MASK_OPT_B;
         next_done_b = 1'b1;
      end
   end

   // Read mux; the variant bit is a constant, not register state.
   always_comb begin
      next_rdata = 8'h00;
      if (rd_stb && sel_a) begin
         next_rdata = opt_a;
      end else if (rd_stb && sel_b) begin
         next_rdata = opt_b;
         next_rdata[wso_pkg::B_VARIANT] = wso_pkg::VARIANT_VALUE[0];
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         opt_a <= wso_pkg::RST_OPT_A;
         opt_b <= wso_pkg::RST_OPT_B;
         done_a <= 1'b0;
         done_b <= 1'b0;
         rdata <= 8'h00;
      end else begin
         opt_a <= next_opt_a;
         opt_b <= next_opt_b;
         done_a <= next_done_a;
         done_b <= next_done_b;
         rdata <= next_rdata;
      end
   end

   // Option outputs decode from the held register bits, with in_stop gating the active flag; the variant indicator is a constant.
   assign volt_monitor_power_en = opt_a[wso_pkg::A_VM_PWR];
   assign volt_monitor_active = opt_a[wso_pkg::A_VM_PWR] &&
      (!in_stop || opt_a[wso_pkg::A_VM_STOP]);
   assign volt_monitor_reset_en = opt_a[wso_pkg::A_VM_RST];
   assign trip_en = volt_monitor_active && volt_monitor_reset_en;
   assign short_stop_recovery = opt_a[wso_pkg::A_SHORT_REC];
   // Keeping short recovery clear with a crystal is left to software.
   assign stop_recovery_cycles = short_stop_recovery ?
      wso_pkg::STOP_REC_SHORT : wso_pkg::STOP_REC_LONG;
   assign stop_instr_enable = opt_a[wso_pkg::A_STOP_EN];
   assign stop_opcode_illegal = !stop_instr_enable;
   assign watchdog_short_period = opt_a[wso_pkg::A_WD_SHORT];
   assign watchdog_period = watchdog_short_period ?
      wso_pkg::WD_PERIOD_SHORT : wso_pkg::WD_PERIOD_LONG;
   assign watchdog_disable = opt_a[wso_pkg::A_WD_DIS];
   assign eeprom_timebase_clk_sel = opt_b[wso_pkg::B_EE_CLK];
   assign variant_indicator = wso_pkg::VARIANT_VALUE[0];

   wso_trip_filter wso_trip_filter_i (
      .clk(clk),
      .reset_n(reset_n),
      .enable(trip_en),
      .below_fall(vm_below_fall),
      .above_rise(vm_above_rise),
      .reset_req(volt_monitor_chip_reset)
   );

   property p_second_write_ignored;
      @(posedge clk) disable iff (!reset_n)
      (wr_stb && sel_a && done_a) |=> $stable(opt_a);
   endproperty
   a_second_write_ignored: assert property (p_second_write_ignored)
      else $error("Option A changed after its first write.");

   property p_first_write_lands;
      @(posedge clk) disable iff (!reset_n)
      (wr_stb && sel_b && !done_b) |=>
         opt_b == ($past(wdata) & wso_pkg::MASK_OPT_B) && done_b;
   endproperty
   a_first_write_lands: assert property (p_first_write_lands)
      else $error("First write to option B did not land.");

   property p_read_default;
      @(posedge clk) disable iff (!reset_n)
      (rd_stb && sel_a && !done_a) |=> rdata == wso_pkg::RST_OPT_A;
   endproperty
   a_read_default: assert property (p_read_default)
      else $error("Option A did not read its default before a write.");

   property p_variant_read;
      @(posedge clk) disable iff (!reset_n)
      (rd_stb && sel_b) |=> rdata[wso_pkg::B_VARIANT] == 1'b1;
   endproperty
   a_variant_read: assert property (p_variant_read)
      else $error("Variant indicator did not read one.");

   property p_stop_monitor;
      @(posedge clk) disable iff (!reset_n)
      (in_stop && !opt_a[wso_pkg::A_VM_STOP]) |-> !volt_monitor_active;
   endproperty
   a_stop_monitor: assert property (p_stop_monitor)
      else $error("Voltage monitor active in stop without its bit.");

   property p_no_trip_when_blocked;
      @(posedge clk) disable iff (!reset_n)
      !volt_monitor_reset_en |=> !volt_monitor_chip_reset;
   endproperty
   a_no_trip_when_blocked: assert property (p_no_trip_when_blocked)
      else $error("Chip reset from monitor while reset is blocked.");

   property p_power_off;
      @(posedge clk) disable iff (!reset_n)
      !volt_monitor_power_en |-> !volt_monitor_active;
   endproperty
   a_power_off: assert property (p_power_off)
      else $error("Voltage monitor active while powered down.");

   property p_recovery_count;
      @(posedge clk) disable iff (!reset_n)
      stop_recovery_cycles == (short_stop_recovery ? 13'h0020 : 13'h1000);
   endproperty
   a_recovery_count: assert property (p_recovery_count)
      else $error("Stop recovery count wrong.");

   property p_wd_period;
      @(posedge clk) disable iff (!reset_n)
      watchdog_period == (watchdog_short_period ? 18'h01ff0 : 18'h3fff0);
   endproperty
   a_wd_period: assert property (p_wd_period)
      else $error("Watchdog period wrong.");

   property p_stop_illegal;
      @(posedge clk) disable iff (!reset_n)
      stop_opcode_illegal != opt_a[wso_pkg::A_STOP_EN];
   endproperty
   a_stop_illegal: assert property (p_stop_illegal)
      else $error("Stop legality does not follow its bit.");

   property p_wd_disable;
      @(posedge clk) disable iff (!reset_n)
      watchdog_disable == opt_a[wso_pkg::A_WD_DIS];
   endproperty
   a_wd_disable: assert property (p_wd_disable)
      else $error("Watchdog disable does not follow its bit.");

   property p_ee_clk;
      @(posedge clk) disable iff (!reset_n)
      eeprom_timebase_clk_sel == opt_b[wso_pkg::B_EE_CLK];
   endproperty
   a_ee_clk: assert property (p_ee_clk)
      else $error("Eeprom clock select does not follow its bit.");

   // Locking, read data and decode checks that tests seldom reach.
   property p_b_locked;
      @(posedge clk) disable iff (!reset_n)
      (wr_stb && sel_b && done_b) |=> $stable(opt_b);
   endproperty
   a_b_locked: assert property (p_b_locked)
      else $error("Option B changed after its first write.");

   property p_a_done;
      @(posedge clk) disable iff (!reset_n)
      (wr_stb && sel_a) |=> done_a;
   endproperty
   a_a_done: assert property (p_a_done)
      else $error("Option A not locked after a write.");

   property p_b_done;
      @(posedge clk) disable iff (!reset_n)
      (wr_stb && sel_b) |=> done_b;
   endproperty
   a_b_done: assert property (p_b_done)
      else $error("Option B not locked after a write.");

   property p_a_lands;
      @(posedge clk) disable iff (!reset_n)
      (wr_stb && sel_a && !done_a) |=>
         opt_a == ($past(wdata) & wso_pkg::MASK_OPT_A) && done_a;
   endproperty
   a_a_lands: assert property (p_a_lands)
      else $error("First write to option A did not land.");

   property p_b_default;
      @(posedge clk) disable iff (!reset_n)
      (rd_stb && sel_b && !done_b) |=> rdata[6:0] == wso_pkg::RST_OPT_B[6:0];
   endproperty
   a_b_default: assert property (p_b_default)
      else $error("Option B did not read its default before a write.");

   property p_unmapped_zero;
      @(posedge clk) disable iff (!reset_n)
      (rd_stb && addr[1]) |=> rdata == 8'h00;
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero)
      else $error("Unmapped read did not return zero.");

   property p_reserved_zero;
      @(posedge clk) disable iff (!reset_n)
      (opt_a & ~wso_pkg::MASK_OPT_A) == 8'h00 &&
         (opt_b & ~wso_pkg::MASK_OPT_B) == 8'h00;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("A reserved option bit is set.");

   property p_reset_en;
      @(posedge clk) disable iff (!reset_n)
      volt_monitor_reset_en == opt_a[wso_pkg::A_VM_RST];
   endproperty
   a_reset_en: assert property (p_reset_en)
      else $error("Monitor reset enable does not follow its bit.");

   property p_run_active;
      @(posedge clk) disable iff (!reset_n)
      (!in_stop && volt_monitor_power_en) |-> volt_monitor_active;
   endproperty
   a_run_active: assert property (p_run_active)
      else $error("Powered voltage monitor not active in run.");

   property p_stop_active;
      @(posedge clk) disable iff (!reset_n)
      (in_stop && volt_monitor_power_en && opt_a[wso_pkg::A_VM_STOP]) |->
         volt_monitor_active;
   endproperty
   a_stop_active: assert property (p_stop_active)
      else $error("Voltage monitor off in stop with both bits set.");

   property p_short_rec;
      @(posedge clk) disable iff (!reset_n)
      short_stop_recovery == opt_a[wso_pkg::A_SHORT_REC];
   endproperty
   a_short_rec: assert property (p_short_rec)
      else $error("Short recovery does not follow its bit.");

   property p_wd_short;
      @(posedge clk) disable iff (!reset_n)
      watchdog_short_period == opt_a[wso_pkg::A_WD_SHORT];
   endproperty
   a_wd_short: assert property (p_wd_short)
      else $error("Watchdog short period does not follow its bit.");

   property p_trip_release;
      @(posedge clk) disable iff (!reset_n)
      (volt_monitor_chip_reset && vm_above_rise) |=> !volt_monitor_chip_reset;
   endproperty
   a_trip_release: assert property (p_trip_release)
      else $error("Monitor reset held after the supply rose.");

   property p_stop_en;
      @(posedge clk) disable iff (!reset_n)
      stop_instr_enable == opt_a[wso_pkg::A_STOP_EN];
   endproperty
   a_stop_en: assert property (p_stop_en)
      else $error("Stop enable does not follow its bit.");
endmodule
`default_nettype wire

//--- test/wso_option_bank_tb.sv
// Purpose: Self-checking bench for the write-once option register bank.
// Assumes: Read data stands only in the cycle after the read strobe.
// Notes: Each table row starts from reset, since a register locks after
//    its first write and could not take a second pattern otherwise.
`timescale 1ns/1ps
`default_nettype none
module wso_option_bank_tb;
   // Row layout: e is power, active, reset_en, short_rec, stop, wd_short,
   // wd_dis.
   typedef struct packed {
      logic [7:0] wa;
      logic [7:0] wb;
      logic stp;
      logic [6:0] e;
   } wso_row_t;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [1:0] addr = 2'h0;
   logic [7:0] wdata = 8'h00;
   logic wr_stb = 1'b0;
   logic rd_stb = 1'b0;
   logic in_stop = 1'b0;
   logic below = 1'b0;
   logic above = 1'b0;
   logic [7:0] rdata;
   logic power_en, active, reset_en, chip_reset, short_rec, stop_en, illegal;
   logic wd_short, wd_dis, ee_sel, variant;
   logic [12:0] stop_cycles;
   logic [17:0] wd_period;
   int miscompares = 0;
   int comparisons = 0;
   int cycles = 0;
   wso_row_t rows [6];

   wso_option_bank wso_option_bank_i (
      .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .in_stop(in_stop),
      .vm_below_fall(below), .vm_above_rise(above),
      .volt_monitor_power_en(power_en), .volt_monitor_active(active),
      .volt_monitor_reset_en(reset_en), .volt_monitor_chip_reset(chip_reset),
      .short_stop_recovery(short_rec), .stop_recovery_cycles(stop_cycles),
      .stop_instr_enable(stop_en), .stop_opcode_illegal(illegal),
      .watchdog_short_period(wd_short), .watchdog_period(wd_period),
      .watchdog_disable(wd_dis), .eeprom_timebase_clk_sel(ee_sel),
      .variant_indicator(variant)
   );

   // Free-running 20 MHz clock.
   always #25 clk = ~clk;

   // A hang is cut short well past the roughly 150 cycles the run needs.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         miscompares++;
         give_verdict();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [1:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask

   // Read data is sampled just after the edge that takes the strobe.
   task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1 chk(rdata, exp);
   endtask

   task automatic do_reset(input int n);
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (n) @(posedge clk);
      reset_n <= 1'b1;
   endtask

   // Main sequence: table of option patterns, then the awkward cases.
   initial begin
      rows[0] = '{8'h00, 8'h00, 1'b0, 7'b0000000};
      // Rows 1 and 3 set short recovery; the bench has no crystal.
      rows[1] = '{8'h7f, 8'h01, 1'b1, 7'b1111111};
      rows[2] = '{8'h2a, 8'hff, 1'b1, 7'b1000110};
      rows[3] = '{8'h55, 8'hfe, 1'b0, 7'b0011001};
      rows[4] = '{8'h21, 8'h00, 1'b1, 7'b1100000};
      rows[5] = '{8'h20, 8'h00, 1'b0, 7'b1100000};
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      foreach (rows[i]) begin
         do_reset(2);
         in_stop <= rows[i].stp;
         wr(2'h0, rows[i].wa);
         wr(2'h1, rows[i].wb);
         rd_chk(2'h0, rows[i].wa & 8'h7f);
         rd_chk(2'h1, {1'b1, 6'h00, rows[i].wb[0]});
         chk(power_en, rows[i].e[6]);
         chk(active, rows[i].e[5]);
         chk(reset_en, rows[i].e[4]);
         chk(short_rec, rows[i].e[3]);
         chk(stop_cycles, rows[i].e[3] ? 32'h20 : 32'h1000);
         chk(stop_en, rows[i].e[2]);
         chk(illegal, !rows[i].e[2]);
         chk(wd_short, rows[i].e[1]);
         chk(wd_period, rows[i].e[1] ? 32'h1ff0 : 32'h3fff0);
         chk(wd_dis, rows[i].e[0]);
         chk(ee_sel, rows[i].wb[0]);
         chk(variant, 1'b1);
      end
      // Defaults after a mid-run reset, then locking by the first write.
      do_reset(3);
      in_stop <= 1'b0;
      rd_chk(2'h0, 8'h60);
      rd_chk(2'h1, 8'h80);
      wr(2'h2, 8'h7f);
      wr(2'h0, 8'h80);
      wr(2'h0, 8'h7f);
      wr(2'h1, 8'h01);
      wr(2'h1, 8'h00);
      rd_chk(2'h0, 8'h00);
      rd_chk(2'h1, 8'h81);
      rd_chk(2'h2, 8'h00);
      rd_chk(2'h3, 8'h00);
      chk(power_en, 1'b0);
      // Trip filter: eight lows are not enough, nine are; held until rise.
      do_reset(2);
      @(posedge clk);
      below <= 1'b1;
      repeat (8) @(posedge clk);
      below <= 1'b0;
      #1 chk(chip_reset, 1'b0);
      @(posedge clk);
      below <= 1'b1;
      repeat (8) @(posedge clk);
      #1 chk(chip_reset, 1'b0);
      repeat (2) @(posedge clk);
      #1 chk(chip_reset, 1'b1);
      @(posedge clk);
      below <= 1'b0;
      repeat (4) @(posedge clk);
      #1 chk(chip_reset, 1'b1);
      @(posedge clk);
      above <= 1'b1;
      repeat (2) @(posedge clk);
      #1 chk(chip_reset, 1'b0);
      // In stop with the in-stop bit clear the monitor must stay quiet.
      @(posedge clk);
      above <= 1'b0;
      in_stop <= 1'b1;
      below <= 1'b1;
      repeat (12) @(posedge clk);
      #1 chk(chip_reset, 1'b0);
      chk(active, 1'b0);
      give_verdict();
   end
endmodule
`default_nettype wire
